// File: osf_top.sv
// Serial-controlled fault logic for an eight-channel load switch
`timescale 1ns/1ps
`include "osf_map.svh"

module osf_top #(
  parameter int FILT_CYC = `OSF_FILT_CYC,
  parameter int SPACE_CYC = `OSF_SPACE_CYC
) (
  // Clock and reset (reset is logic-supply undervoltage)
  input wire logic clk,
  input wire logic arst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Per-output analog detectors
  input wire logic [7:0] overtemp,
  input wire logic [7:0] overcurrent,
  input wire logic [7:0] open_cmp,
  // Supply monitors
  input wire logic load_supply_ov,
  input wire logic load_supply_uv,
  // Output gate drive, output_eight_bit is bit 7, output_one_bit is bit 0
  output logic [7:0] out_on,
  // Status
  output logic [7:0] cmd_word,
  output logic [7:0] fault_status_word,
  output logic filter_busy,
  output logic spacing_short,
  output logic frame_misaligned,
  output logic status_unreliable
);

  // ----------------------------------------------------------------
  // Constants at the width of the counters
  // ----------------------------------------------------------------
  localparam logic [15:0] FILT_LOAD = FILT_CYC[15:0];
  localparam logic [15:0] SPACE_MIN = SPACE_CYC[15:0];
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam int SYNC_W = 28;

  osf_pkg::osf_state_t s;
  osf_pkg::osf_state_t next_s;

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic sclk_s;
  logic cs_n_s;
  logic si_s;
  logic ov_s;
  logic uv_s;
  logic [7:0] ot_s;
  logic [7:0] oc_s;
  logic [7:0] ol_s;

  assign sync_in = {sclk, cs_n, si, load_supply_ov, overtemp, overcurrent, open_cmp};

  osf_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(sync_in),
    .q(sync_out)
  );

  // Supply-low status is only advisory, so it gets its own synchroniser
  osf_sync #(
    .WIDTH(1)
  ) u_sync_uv (
    .clk(clk),
    .arst_n(arst_n),
    .d(load_supply_uv),
    .q(uv_s)
  );

  assign sclk_s = sync_out[27];
  assign cs_n_s = sync_out[26];
  assign si_s = sync_out[25];
  assign ov_s = sync_out[24];
  assign ot_s = sync_out[23:16];
  assign oc_s = sync_out[15:8];
  assign ol_s = sync_out[7:0];

  // ----------------------------------------------------------------
  // Edge detection on the sampled link pins
  // ----------------------------------------------------------------
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic filt_done;
  logic [7:0] on_fault;
  logic [7:0] status_now;

  assign sclk_rise = sclk_s & ~s.sclk_d;
  assign sclk_fall = ~sclk_s & s.sclk_d;
  assign cs_fall = ~cs_n_s & s.cs_n_d;
  assign cs_rise = cs_n_s & ~s.cs_n_d;
  assign filt_done = (s.filt_cnt == 16'h0000);

  // On-state faults only mean something while the output is commanded on
  assign on_fault = s.cmd & (ot_s | oc_s);

  // Snapshot offered to the host: latched faults plus live on-state faults
  assign status_now = s.open_lat | s.on_lat | on_fault;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sclk_d = sclk_s;
    next_s.cs_n_d = cs_n_s;
    next_s.supply_low = uv_s;

    // Filter runs down after each frame end
    if (!filt_done) begin
      next_s.filt_cnt = s.filt_cnt - 16'h0001;
    end

    // Gap since the last frame end, saturating
    if (s.gap_cnt != CNT_MAX) begin
      next_s.gap_cnt = s.gap_cnt + 16'h0001;
    end

    unique case (s.frame)
      osf_pkg::OSF_IDLE: begin
        // Clock edges outside a frame are ignored
        if (cs_fall) begin
          next_s.frame = osf_pkg::OSF_SHIFT;
          next_s.shift = status_now;
          next_s.so_bit = status_now[`OSF_MSB];
          // Reading hands the latched faults to the host; new events set again below
          next_s.open_lat = `OSF_STAT_RST;
          next_s.on_lat = `OSF_STAT_RST;
          next_s.bit_cnt = 3'h0;
          next_s.got_bit = 1'b0;
          // Host too early: report cannot yet be trusted
          next_s.spacing_short = (s.gap_cnt < SPACE_MIN);
        end
      end
      osf_pkg::OSF_SHIFT: begin
        if (cs_rise) begin
          next_s.frame = osf_pkg::OSF_IDLE;
          // Whatever sits in the register is the last byte received
          next_s.cmd = s.shift;
          next_s.filt_cnt = FILT_LOAD;
          next_s.gap_cnt = 16'h0000;
          next_s.misaligned = ~s.got_bit | (s.bit_cnt != 3'h0);
        end else begin
          if (sclk_fall) begin
            // Capture on falling edge, MSB first
            next_s.shift = {s.shift[6:0], si_s};
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            next_s.got_bit = 1'b1;
          end
          if (sclk_rise) begin
            // Present the next bit on the rising edge
            next_s.so_bit = s.shift[`OSF_MSB];
          end
        end
      end
    endcase

    // Set wins over the read clear in the same cycle
    next_s.open_lat = next_s.open_lat | (~s.cmd & ol_s & {8{filt_done}});
    next_s.on_lat = next_s.on_lat | on_fault;

    // Gate drive: per-output thermal cut, global overvoltage cut.
    // The command word is kept untouched, so recovery restores it.
    // Load-supply undervoltage deliberately plays no part here.
    next_s.drive = s.cmd & ~ot_s & {8{~ov_s}};
  end

  // ----------------------------------------------------------------
  // State register; logic-supply loss clears outputs and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The serial output is released between frames so several devices may share it
  assign so_out = s.so_bit;
  assign so_oe = (s.frame == osf_pkg::OSF_SHIFT);
  assign out_on = s.drive;
  assign cmd_word = s.cmd;
  assign fault_status_word = s.open_lat | s.on_lat;
  assign filter_busy = ~filt_done;
  assign spacing_short = s.spacing_short;
  assign frame_misaligned = s.misaligned;
  assign status_unreliable = s.supply_low;

endmodule : osf_top

// File: osf_map.svh
// Constants for the octal switch fault logic: widths, reset values, timing counts
`ifndef OSF_MAP_SVH
`define OSF_MAP_SVH

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define OSF_CH 8
`define OSF_MSB 7
`define OSF_CMD_RST 8'h00
`define OSF_STAT_RST 8'h00
`define OSF_BITS_PER_BYTE_M1 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OSF_CLK_PERIOD_NS 10
`define OSF_FILT_MIN_US 100
`define OSF_FILT_CYC ((`OSF_FILT_MIN_US * 1000 + `OSF_CLK_PERIOD_NS - 1) / `OSF_CLK_PERIOD_NS)
`define OSF_SPACE_MIN_US 300
`define OSF_SPACE_CYC ((`OSF_SPACE_MIN_US * 1000 + `OSF_CLK_PERIOD_NS - 1) / `OSF_CLK_PERIOD_NS)
`define OSF_CNT_W 16

`endif

// File: osf_pkg.sv
// Types shared by the octal switch fault logic
package osf_pkg;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    OSF_IDLE  = 1'b0,
    OSF_SHIFT = 1'b1
  } osf_frame_t;

  // ----------------------------------------------------------------
  // Complete state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    osf_frame_t frame;
    logic sclk_d;
    logic cs_n_d;
    logic [7:0] shift;
    logic so_bit;
    logic [7:0] cmd;
    logic [7:0] open_lat;
    logic [7:0] on_lat;
    logic [7:0] drive;
    logic [15:0] filt_cnt;
    logic [15:0] gap_cnt;
    logic [2:0] bit_cnt;
    logic got_bit;
    logic misaligned;
    logic spacing_short;
    logic supply_low;
  } osf_state_t;

endpackage : osf_pkg

// File: osf_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps

module osf_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } osf_sync_t;

  osf_sync_t s;
  osf_sync_t next_s;

  // ----------------------------------------------------------------
  // Stage one feeds stage two only
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;

endmodule : osf_sync

// File: osf_top_properties.sv
// Concurrent checks on the octal switch fault logic ports
`timescale 1ns/1ps
module osf_top_properties #(
  parameter int FILT_CYC = 10000,
  parameter int SPACE_CYC = 30000
) (
  // Clock, reset and frame
  input wire logic clk,
  input wire logic arst_n,
  input wire logic so_oe,
  // Detectors
  input wire logic [7:0] overtemp,
  input wire logic load_supply_ov,
  // Drive and status
  input wire logic [7:0] out_on,
  input wire logic [7:0] cmd_word,
  input wire logic [7:0] fault_status_word,
  input wire logic filter_busy
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Detectors pass two sync flops, so six steady samples cover the latency
  sequence s_hot_steady; $stable(overtemp) [*6]; endsequence
  sequence s_quiet; (overtemp == 8'h00 && !load_supply_ov) [*6]; endsequence
  // Needs FILT_CYC above 8
  sequence s_filt_run; ##1 filter_busy [*8]; endsequence
  property p_ot_off; s_hot_steady |-> (out_on & overtemp) == 8'h00; endproperty
  a_ot_off: assert property (p_ot_off) else $error("hot output still driven");
  property p_ov_off; load_supply_ov [*6] |-> out_on == 8'h00; endproperty
  a_ov_off: assert property (p_ov_off) else $error("output on in overvoltage");
  property p_follow; s_quiet |-> out_on == $past(cmd_word); endproperty
  a_follow: assert property (p_follow) else $error("drive differs from command");
  property p_sub; (out_on & ~$past(cmd_word)) == 8'h00; endproperty
  a_sub: assert property (p_sub) else $error("output on without command");
  property p_cmd_frame; cmd_word != $past(cmd_word) |-> $fell(so_oe); endproperty
  a_cmd_frame: assert property (p_cmd_frame) else $error("command moved off frame end");
  property p_filter; $fell(so_oe) |-> s_filt_run; endproperty
  a_filter: assert property (p_filter) else $error("filter not started");
  property p_open_wait;
    filter_busy |=> (fault_status_word & ~$past(fault_status_word) & ~cmd_word) == 8'h00;
  endproperty
  a_open_wait: assert property (p_open_wait) else $error("open flagged inside filter");
  property p_latch_hold;
    !so_oe && !$past(so_oe) |-> ($past(fault_status_word) & ~fault_status_word) == 8'h00;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("fault bit lost");
endmodule : osf_top_properties

bind osf_top osf_top_properties #(.FILT_CYC(FILT_CYC), .SPACE_CYC(SPACE_CYC))
  i_osf_top_properties (
  .clk(clk), .arst_n(arst_n), .so_oe(so_oe), .overtemp(overtemp),
  .load_supply_ov(load_supply_ov), .out_on(out_on), .cmd_word(cmd_word),
  .fault_status_word(fault_status_word), .filter_busy(filter_busy)
);

// File: osf_host_model.sv
// Host serial master model for the switch link
`timescale 1ns/1ps
module osf_host_model #(
  parameter int GAP = 60
) (
  // Clock
  input wire logic clk,
  // Link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_out
);
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Half period of 8 clocks gives the 160 ns link clock
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    repeat (GAP) @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      si <= tx[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      rx = {rx[14:0], so_out};
      repeat (8) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released data line shows the inverse so a stale bit never passes
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask : xfer
  // Link clock edges with the device deselected
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk);
      sclk <= ~sclk;
      si <= ~si;
    end
  endtask : stray
endmodule : osf_host_model

// File: osf_top_tb.sv
// Self-checking bench for the octal switch fault logic
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module osf_top_tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, cs_n, si, so_out, so_oe, ov = 1'b0, uv = 1'b0;
  logic [7:0] overtemp = 8'h00, overcurrent = 8'h00, open_cmp = 8'h00;
  logic [7:0] out_on, cmd_word, fsw, cmd, ot_v, oc_v, pat;
  logic filter_busy, spacing_short, frame_misaligned, status_unreliable;
  logic [15:0] rx;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  // Spacing limit sits between a back-to-back write (about 67 clocks) and a spaced one
  osf_top #(.FILT_CYC(20), .SPACE_CYC(80)) i_osf_top (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe), .overtemp(overtemp), .overcurrent(overcurrent), .open_cmp(open_cmp),
    .load_supply_ov(ov), .load_supply_uv(uv), .out_on(out_on), .cmd_word(cmd_word),
    .fault_status_word(fsw), .filter_busy(filter_busy), .spacing_short(spacing_short),
    .frame_misaligned(frame_misaligned), .status_unreliable(status_unreliable));
  osf_host_model #(.GAP(60)) i_osf_host_model (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out));
  function automatic logic [7:0] exp_out(logic [7:0] c, logic [7:0] t, logic v);
    return v ? 8'h00 : (c & ~t);
  endfunction : exp_out
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic send(input logic [15:0] tx, input int n);
    i_osf_host_model.xfer(tx, n, rx);
  endtask : send
  task automatic integrity();
    // Host keeps its write spacing after reset
    tick(20);
    pat = 8'($urandom);
    cmd = 8'($urandom);
    send({pat, cmd}, 16);
    `CHK("status", 8'h00, rx[15:8]);
    `CHK("echo", pat, rx[7:0]);
    `CHK("applied", cmd, cmd_word);
    `CHK("drive", exp_out(cmd, 8'h00, 1'b0), out_on);
    `CHK("spacing", 1'b0, spacing_short);
    $display("done: integrity");
  endtask : integrity
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'h7efdfb93));
    tick(8);
    arst_n <= 1'b1;
    tick(3);
    `CHK("reset_drive", 8'h00, out_on);
    integrity();
    for (int j = 0; j < 4; j++) begin
      ot_v = 8'h01 << $urandom_range(7, 0);
      oc_v = 8'($urandom);
      cmd = 8'($urandom) | ot_v;
      send(16'(cmd), 8);
      `CHK("aligned", 1'b0, frame_misaligned);
      overtemp <= ot_v;
      overcurrent <= oc_v;
      tick(10);
      `CHK("hot_off", exp_out(cmd, ot_v, 1'b0), out_on);
      send(16'(cmd), 8);
      `CHK("fault", (ot_v | oc_v) & cmd, rx[7:0]);
      if (j[0]) begin
        cmd = cmd & ~ot_v;
        send(16'(cmd), 8);
      end
      overtemp <= 8'h00;
      overcurrent <= 8'h00;
      tick(10);
      `CHK("cooled", exp_out(cmd, 8'h00, 1'b0), out_on);
    end
    $display("done: overtemperature");
    ov <= 1'b1;
    uv <= 1'b1;
    tick(10);
    `CHK("ov_off", 8'h00, out_on);
    `CHK("unreliable", 1'b1, status_unreliable);
    ov <= 1'b0;
    tick(10);
    `CHK("ov_back", exp_out(cmd, 8'h00, 1'b0), out_on);
    uv <= 1'b0;
    i_osf_host_model.stray(6);
    tick(6);
    `CHK("reliable", 1'b0, status_unreliable);
    `CHK("hold", cmd, cmd_word);
    `CHK("idle", 1'b0, so_oe);
    $display("done: supplies");
    pat = 8'($urandom);
    send(16'({4'h5, pat}), 12);
    `CHK("last_byte", pat, cmd_word);
    `CHK("misaligned", 1'b1, frame_misaligned);
    send(16'h00ff, 8);
    `CHK("too_soon", 1'b1, spacing_short);
    open_cmp <= 8'hff;
    tick(30);
    `CHK("on_open", 8'h00, fsw);
    send(16'h00f0, 8);
    `CHK("filter", 1'b1, filter_busy);
    `CHK("early", 8'h00, fsw);
    `CHK("spaced", 1'b0, spacing_short);
    tick(30);
    `CHK("open", 8'h0f, fsw);
    open_cmp <= 8'h00;
    tick(10);
    `CHK("latched", 8'h0f, fsw);
    arst_n <= 1'b0;
    tick(2);
    `CHK("uv_off", 8'h00, out_on);
    `CHK("uv_clear", 8'h00, fsw);
    arst_n <= 1'b1;
    tick(3);
    $display("done: open load");
    integrity();
    send(16'h0000, 8);
    `CHK("sleep", 8'h00, out_on);
    $display("done: sleep");
    print_verdict();
  end
  initial begin
    tick(20000);
    num_errors++;
    print_verdict();
  end
endmodule : osf_top_tb
